// ---- common/kes_defines.svh ----
// Constants for the keyboard controller emulation status block.
// Assumes an 8-bit host I/O address and 8-bit configuration index space.
`ifndef KES_DEFINES_SVH
`define KES_DEFINES_SVH

// ----------------------------------------------------------------
// Host I/O ports
// ----------------------------------------------------------------
`define KES_PORT_DATA 8'h60
`define KES_PORT_CMD 8'h64

// ----------------------------------------------------------------
// Configuration index registers
// ----------------------------------------------------------------
`define KES_IDX_SEL 8'hC0
`define KES_IDX_EN 8'hC1
`define KES_IDX_STW 8'hC5
`define KES_SEL_AUX 0
`define KES_EN_LO 2
`define KES_EN_HI 3

// ----------------------------------------------------------------
// Status bit positions, reset and idle values
// ----------------------------------------------------------------
`define KES_B_OBF 0
`define KES_B_IBF 1
`define KES_B_SYS 2
`define KES_B_CMD 3
`define KES_B_ENB 4
`define KES_B_TTO 5
`define KES_B_RTO 6
`define KES_B_PAR 7
`define KES_RST_BYTE 8'h00
`define KES_RD_IDLE 8'hFF
`define KES_EN_OFF 2'h0

`endif

// ---- common/kes_pkg.sv ----
// Types for the keyboard controller emulation status block.
// Assumes kes_defines.svh is included by the users of the bit positions.
package kes_pkg;
   typedef logic [7:0] kes_byte_t;
   typedef logic [1:0] kes_en_t;
endpackage

// ---- common/kes_if.sv ----
// Carries buffer state from the status logic to the interrupt logic.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface kes_if;
   logic obf;
   logic aux_mode;
   logic aux_full;
   logic data_rd;
   logic kbd_irq;
   logic mouse_irq;
   modport ctl (output obf, output aux_mode, output aux_full, output data_rd,
                input kbd_irq, input mouse_irq);
   modport irq (input obf, input aux_mode, input aux_full, input data_rd,
                output kbd_irq, output mouse_irq);
endinterface

// ---- hw/kes_irq.sv ----
// Keyboard and mouse interrupt request generation.
// Assumes output-buffer state and data-port reads arrive over kes_if.
`timescale 1ns/10ps
module kes_irq (
   input wire logic clock,
   input wire logic sys_rst,
   kes_if.irq bus
);
   logic kbd_r, kbd_nxt, mouse_r, mouse_nxt;

   // ----------------------------------------------------------------
   // Request lines
   // ----------------------------------------------------------------
   // A data-port read drops the line on the next edge, the same edge that clears
   // the buffer flag, rather than a cycle later when the cleared flag is seen here.
   // In mouse mode a keyboard byte leaves bit 5 clear, so the byte still
   // raises the keyboard line rather than leaving both lines quiet.
   always_comb begin
      kbd_nxt = bus.obf && !(bus.aux_mode && bus.aux_full) && !bus.data_rd;
      mouse_nxt = bus.obf && bus.aux_mode && bus.aux_full && !bus.data_rd;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         kbd_r <= 1'b0;
         mouse_r <= 1'b0;
      end else begin
         kbd_r <= kbd_nxt;
         mouse_r <= mouse_nxt;
      end
   end

   assign bus.kbd_irq = kbd_r;
   assign bus.mouse_irq = mouse_r;

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   chk_kbd_irq_set: assert property (bus.obf && !(bus.aux_mode && bus.aux_full) && !bus.data_rd
      |=> bus.kbd_irq)
      else $error("keyboard request not raised");
   chk_mouse_irq_set: assert property (bus.obf && bus.aux_mode && bus.aux_full && !bus.data_rd
      |=> bus.mouse_irq)
      else $error("mouse request not raised");
   chk_irq_rd_clear: assert property (bus.data_rd |=> !bus.kbd_irq && !bus.mouse_irq)
      else $error("request survived data port read");
   chk_irq_exclusive: assert property (!(bus.kbd_irq && bus.mouse_irq))
      else $error("both requests active");
endmodule

// ---- hw/kes_status.sv ----
// Status register of the keyboard controller emulation, host side ports and
// configuration writes from the emulation software.
// Assumes host I/O and configuration strobes are one-cycle pulses on clock.
//
// Summary of operation
// - Status port reads only while the two-bit enable field at C1h is nonzero.
// - Bit 5 is time-out when C0h bit 0 clear, mouse buffer full when set.
// - Command flag set by command port write, cleared by data port write.
// - System flag status bit shows emulated command byte bit two.
// - System flag is 0 after reset until a diagnostic pass is posted.
// - Input full is 1 until the emulation consumes the last host byte.
// - Output full is 1 while a byte waits for the host to read.
// - Mouse mode with bits 0 and 5 set raises the mouse request.
// - Keyboard mode with output full raises the keyboard request.
// - A host data port read clears the active request.
`timescale 1ns/10ps
`include "kes_defines.svh"
module kes_status (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic [7:0] host_addr,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata,
   output logic host_rvalid,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_index,
   input wire logic [7:0] cfg_wdata,
   input wire logic sw_in_rd,
   output logic [7:0] sw_in_data,
   output logic sw_in_is_cmd,
   input wire logic sw_out_wr,
   input wire logic sw_out_aux,
   input wire logic [7:0] sw_out_data,
   output logic keyboard_interrupt_line,
   output logic mouse_interrupt_line
);
   kes_if link ();

   kes_pkg::kes_byte_t stat_r, stat_nxt;
   kes_pkg::kes_byte_t in_byte_r, in_byte_nxt;
   kes_pkg::kes_byte_t out_byte_r, out_byte_nxt;
   kes_pkg::kes_byte_t rdata_r, rdata_nxt;
   kes_pkg::kes_en_t en_r, en_nxt;
   logic aux_mode_r, aux_mode_nxt;
   logic rvalid_r, rvalid_nxt;
   logic enabled, wr_data, wr_cmd, rd_data, rd_stat, stw, host_wr_any;

   // ----------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------
   // Host ports are only claimed while the emulation is enabled; when off,
   // reads answer the idle bus value and writes leave all state alone.
   always_comb begin
      enabled = (en_r != `KES_EN_OFF);
      wr_data = enabled && host_wr && (host_addr == `KES_PORT_DATA);
      wr_cmd = enabled && host_wr && (host_addr == `KES_PORT_CMD);
      rd_data = enabled && host_rd && (host_addr == `KES_PORT_DATA);
      rd_stat = enabled && host_rd && (host_addr == `KES_PORT_CMD);
      stw = cfg_wr && (cfg_index == `KES_IDX_STW);
      host_wr_any = wr_data || wr_cmd;
   end

   // ----------------------------------------------------------------
   // Configuration
   // ----------------------------------------------------------------
   always_comb begin
      en_nxt = en_r;
      aux_mode_nxt = aux_mode_r;
      if (cfg_wr && (cfg_index == `KES_IDX_EN)) begin
         en_nxt = cfg_wdata[`KES_EN_HI:`KES_EN_LO];
      end
      if (cfg_wr && (cfg_index == `KES_IDX_SEL)) begin
         aux_mode_nxt = cfg_wdata[`KES_SEL_AUX];
      end
   end

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   // In both buffer-full flags the setting event is applied last, so a set in
   // the same cycle as a clear wins.
   always_comb begin
      stat_nxt = stat_r;
      in_byte_nxt = in_byte_r;
      out_byte_nxt = out_byte_r;
      if (stw) begin
         stat_nxt[`KES_B_PAR] = cfg_wdata[`KES_B_PAR];
         stat_nxt[`KES_B_RTO] = cfg_wdata[`KES_B_RTO];
         stat_nxt[`KES_B_ENB] = cfg_wdata[`KES_B_ENB];
         stat_nxt[`KES_B_SYS] = cfg_wdata[`KES_B_SYS];
         stat_nxt[`KES_B_TTO] = cfg_wdata[`KES_B_TTO];
      end
      if (sw_in_rd) begin
         stat_nxt[`KES_B_IBF] = 1'b0;
      end
      if (rd_data) begin
         stat_nxt[`KES_B_OBF] = 1'b0;
      end
      if (sw_out_wr) begin
         out_byte_nxt = sw_out_data;
         stat_nxt[`KES_B_OBF] = 1'b1;
         if (aux_mode_r) begin
            stat_nxt[`KES_B_TTO] = sw_out_aux;
         end
      end
      if (host_wr_any) begin
         in_byte_nxt = host_wdata;
         stat_nxt[`KES_B_IBF] = 1'b1;
         stat_nxt[`KES_B_CMD] = wr_cmd;
      end
   end

   // ----------------------------------------------------------------
   // Host read data
   // ----------------------------------------------------------------
   always_comb begin
      rdata_nxt = `KES_RD_IDLE;
      rvalid_nxt = rd_data || rd_stat;
      if (rd_stat) begin
         rdata_nxt = stat_r;
      end else if (rd_data) begin
         rdata_nxt = out_byte_r;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         stat_r <= `KES_RST_BYTE;
         in_byte_r <= `KES_RST_BYTE;
         out_byte_r <= `KES_RST_BYTE;
         rdata_r <= `KES_RD_IDLE;
         rvalid_r <= 1'b0;
         en_r <= `KES_EN_OFF;
         aux_mode_r <= 1'b0;
      end else begin
         stat_r <= stat_nxt;
         in_byte_r <= in_byte_nxt;
         out_byte_r <= out_byte_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         en_r <= en_nxt;
         aux_mode_r <= aux_mode_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt requests
   // ----------------------------------------------------------------
   assign link.obf = stat_r[`KES_B_OBF];
   assign link.aux_mode = aux_mode_r;
   assign link.aux_full = stat_r[`KES_B_TTO];
   assign link.data_rd = rd_data;

   kes_irq u_irq (
      .clock(clock),
      .sys_rst(sys_rst),
      .bus(link.irq)
   );

   assign host_rdata = rdata_r;
   assign host_rvalid = rvalid_r;
   assign sw_in_data = in_byte_r;
   assign sw_in_is_cmd = stat_r[`KES_B_CMD];
   assign keyboard_interrupt_line = link.kbd_irq;
   assign mouse_interrupt_line = link.mouse_irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   chk_read_gate_off: assert property (host_rd && en_r == `KES_EN_OFF
      |=> !host_rvalid && host_rdata == `KES_RD_IDLE)
      else $error("status read answered while disabled");
   chk_stat_read_val: assert property (rd_stat |=> host_rvalid && host_rdata == $past(stat_r))
      else $error("status read returned wrong byte");
   chk_cmd_flag: assert property (wr_cmd |=> stat_r[`KES_B_CMD] ##0 stat_r[`KES_B_IBF])
      else $error("command write not recorded");
   chk_data_flag: assert property (wr_data |=> !stat_r[`KES_B_CMD] && stat_r[`KES_B_IBF])
      else $error("data write not recorded");
   chk_ibf_hold: assert property (stat_r[`KES_B_IBF] && !sw_in_rd |=> stat_r[`KES_B_IBF])
      else $error("input full dropped without software read");
   chk_ibf_clear: assert property (sw_in_rd && !host_wr_any |=> !stat_r[`KES_B_IBF])
      else $error("input full not cleared by software read");
   chk_obf_set: assert property (sw_out_wr |=> stat_r[`KES_B_OBF] ##1 1'b1)
      else $error("output full not set");
   chk_obf_clear: assert property (rd_data && !sw_out_wr |=> !stat_r[`KES_B_OBF])
      else $error("output full not cleared by data read");
   chk_sys_flag: assert property (stw |=> stat_r[`KES_B_SYS] == $past(cfg_wdata[`KES_B_SYS]))
      else $error("system flag not taken from status write");
   chk_sys_stable: assert property (!stw |=> $stable(stat_r[`KES_B_SYS]))
      else $error("system flag changed without status write");
   chk_tto_mode: assert property (!aux_mode_r && !stw |=> $stable(stat_r[`KES_B_TTO]))
      else $error("time-out bit moved outside status write");
endmodule

// ---- verif/kes_sw_model.sv ----
// Emulation software model: drives configuration writes and buffer strobes.
// Assumes the bench calls its tasks from one process on the shared clock.
`timescale 1ns/10ps
module kes_sw_model (
   input wire logic clock,
   output logic cfg_wr,
   output logic [7:0] cfg_index,
   output logic [7:0] cfg_wdata,
   output logic sw_in_rd,
   output logic sw_out_wr,
   output logic sw_out_aux,
   output logic [7:0] sw_out_data
);
   initial begin
      cfg_wr = 1'b0;
      cfg_index = 8'h00;
      cfg_wdata = 8'h00;
      sw_in_rd = 1'b0;
      sw_out_wr = 1'b0;
      sw_out_aux = 1'b0;
      sw_out_data = 8'h00;
   end

   // Data lines show the inverse after a strobe, so a stale value never passes.
   task automatic cfg_write(input logic [7:0] idx, input logic [7:0] d);
      @(posedge clock);
      cfg_wr <= 1'b1;
      cfg_index <= idx;
      cfg_wdata <= d;
      @(posedge clock);
      cfg_wr <= 1'b0;
      cfg_wdata <= ~d;
   endtask

   task automatic put_byte(input logic aux, input logic [7:0] d);
      @(posedge clock);
      sw_out_wr <= 1'b1;
      sw_out_aux <= aux;
      sw_out_data <= d;
      @(posedge clock);
      sw_out_wr <= 1'b0;
      sw_out_data <= ~d;
   endtask

   task automatic take_byte();
      @(posedge clock);
      sw_in_rd <= 1'b1;
      @(posedge clock);
      sw_in_rd <= 1'b0;
   endtask
endmodule

// ---- verif/kbd_ctrl_emulation_status_tb_top.sv ----
// Self-checking bench for the emulation status block.
// Assumes the software model drives the configuration and buffer side.
`timescale 1ns/10ps
`include "kes_defines.svh"
module kbd_ctrl_emulation_status_tb_top;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic host_rd = 1'b0;
   logic host_wr = 1'b0;
   logic [7:0] host_addr = 8'h00;
   logic [7:0] host_wdata = 8'h00;
   logic [7:0] host_rdata, sw_in_data, cfg_index, cfg_wdata, sw_out_data;
   logic host_rvalid, cfg_wr, sw_in_rd, sw_in_is_cmd, sw_out_wr, sw_out_aux;
   logic keyboard_interrupt_line, mouse_interrupt_line;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   int st = 0;
   int q[$];
   logic [15:0] lf = 16'hFE14;

   always #25 clock = ~clock;

   kes_status kes_status_i (.clock(clock), .sys_rst(sys_rst), .host_rd(host_rd), .host_wr(host_wr),
      .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
      .cfg_wr(cfg_wr), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .sw_in_rd(sw_in_rd),
      .sw_in_data(sw_in_data), .sw_in_is_cmd(sw_in_is_cmd), .sw_out_wr(sw_out_wr), .sw_out_aux(sw_out_aux),
      .sw_out_data(sw_out_data), .keyboard_interrupt_line(keyboard_interrupt_line),
      .mouse_interrupt_line(mouse_interrupt_line));
   kes_sw_model m (.clock(clock), .cfg_wr(cfg_wr), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
      .sw_in_rd(sw_in_rd), .sw_out_wr(sw_out_wr), .sw_out_aux(sw_out_aux), .sw_out_data(sw_out_data));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One host cycle; returns just after the taking edge has landed.
   task automatic host(input logic rd, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      host_rd <= rd;
      host_wr <= ~rd;
      host_addr <= a;
      host_wdata <= d;
      @(posedge clock);
      host_rd <= 1'b0;
      host_wr <= 1'b0;
      host_wdata <= ~d;
      #1;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic ok);
      host(1'b1, a, 8'h00);
      chk("host_rvalid", {7'h00, ok}, {7'h00, host_rvalid});
      chk("host_rdata", ok ? e : 8'hFF, host_rdata);
   endtask

   task automatic tally_and_finish();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Hang guard and main sequence
   // ------------------------------------------------------------
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      rd_chk(`KES_PORT_CMD, 8'h00, 1'b0);
      m.cfg_write(`KES_IDX_EN, 8'h04);
      rd_chk(`KES_PORT_CMD, 8'h00, 1'b1);
      $display("test enable done");
      host(1'b0, `KES_PORT_CMD, 8'hA5);
      rd_chk(`KES_PORT_CMD, 8'h0A, 1'b1);
      chk("sw_in_data", 8'hA5, sw_in_data);
      chk("sw_in_is_cmd", 8'h01, {7'h00, sw_in_is_cmd});
      m.take_byte();
      host(1'b0, `KES_PORT_DATA, 8'h3C);
      rd_chk(`KES_PORT_CMD, 8'h02, 1'b1);
      m.take_byte();
      rd_chk(`KES_PORT_CMD, 8'h00, 1'b1);
      $display("test host writes done");
      for (int i = 0; i < 8; i++) begin
         lf = lfsr(lf);
         st = lf[7:0] & 8'hF4;
         m.cfg_write(`KES_IDX_STW, lf[7:0]);
         rd_chk(`KES_PORT_CMD, 8'(st), 1'b1);
      end
      m.cfg_write(`KES_IDX_STW, 8'h00);
      $display("test software flags done");
      // Pass 0: keyboard mode; pass 1: mouse byte in mouse mode; pass 2: keyboard byte in mouse mode.
      for (int md = 0; md < 3; md++) begin
         m.cfg_write(`KES_IDX_SEL, 8'(md != 0));
         lf = lfsr(lf);
         q.push_back(int'(lf[7:0]));
         m.put_byte(md < 2, lf[7:0]);
         @(posedge clock);
         #1;
         chk("keyboard_irq", {7'h00, md != 1}, {7'h00, keyboard_interrupt_line});
         chk("mouse_irq", {7'h00, md == 1}, {7'h00, mouse_interrupt_line});
         rd_chk(`KES_PORT_CMD, (md == 1) ? 8'h21 : 8'h01, 1'b1);
         rd_chk(`KES_PORT_DATA, 8'(q.pop_front()), 1'b1);
         chk("irq_lines", 8'h00, {6'h00, keyboard_interrupt_line, mouse_interrupt_line});
         rd_chk(`KES_PORT_CMD, (md == 1) ? 8'h20 : 8'h00, 1'b1);
         $display("test output buffer mode %0d done", md);
      end
      m.cfg_write(`KES_IDX_STW, 8'h04);
      host(1'b0, `KES_PORT_CMD, 8'h5A);
      m.put_byte(1'b0, 8'h77);
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      #1;
      chk("irq_after_reset", 8'h00, {6'h00, keyboard_interrupt_line, mouse_interrupt_line});
      chk("sw_in_is_cmd", 8'h00, {7'h00, sw_in_is_cmd});
      chk("sw_in_data", 8'h00, sw_in_data);
      rd_chk(`KES_PORT_CMD, 8'h00, 1'b0);
      m.cfg_write(`KES_IDX_EN, 8'h08);
      rd_chk(`KES_PORT_CMD, 8'h00, 1'b1);
      $display("test mid-run reset done");
      m.cfg_write(`KES_IDX_EN, 8'h00);
      rd_chk(`KES_PORT_DATA, 8'h00, 1'b0);
      $display("test disable done");
      tally_and_finish();
   end
endmodule
